// ---- test_usb_out_endpoint_control.sv ----
// register and link sequences for the out endpoint control block
`timescale 1ns/1ns
module test_usb_out_endpoint_control;
  localparam logic [2:0] ACK = {1'b1, uoe_pkg::HS_ACK};
  localparam logic [2:0] NAK = {1'b1, uoe_pkg::HS_NAK};
  localparam logic [2:0] STL = {1'b1, uoe_pkg::HS_STALL};
  localparam logic [7:0] CT  = uoe_pkg::CTRL_ADDR;
  logic                    ref_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [2:0]              hsize = 3'h0;
  logic [31:0]             hwdata = 32'h0;
  logic                    fifoByteRead = 1'b0;
  logic [31:0]             hrdata;
  logic                    hreadyout;
  logic                    hresp;
  logic                    pktLoad;
  logic                    dataToggle;
  logic                    irq;
  logic [7:0]              fifoRdPtr;
  uoe_pkg::uoe_outtxn_t    outTxn;
  uoe_pkg::uoe_handshake_t handshake;
  logic [31:0]             q;
  int                      nMismatch = 0;
  int                      numChecks = 0;

  always #10 ref_clk = ~ref_clk;

  uoe_out_endpoint #(.PTR_W(8)) u_uoe_out_endpoint (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .outTxn(outTxn),
    .fifoByteRead(fifoByteRead), .handshake(handshake), .pktLoad(pktLoad),
    .dataToggle(dataToggle), .fifoRdPtr(fifoRdPtr), .irq(irq)
  );
  uoe_host_model u_uoe_host_model (
    .ref_clk(ref_clk), .handshake(handshake), .pktLoad(pktLoad), .outTxn(outTxn)
  );

  task automatic give_verdict;
    $display("mismatches %0d checks %0d", nMismatch, numChecks);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      nMismatch++;
      give_verdict();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= uoe_pkg::HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, a, 8'h00);
    chk("register", e, q[7:0] & m);
  endtask
  task automatic tx(input logic pid, input logic crc, input logic [2:0] eHs, input logic eLd);
    u_uoe_host_model.send(pid, crc);
    chk("handshake", {5'h0, eHs}, {5'h0, u_uoe_host_model.seenHs});
    chk("pktLoad", {7'h0, eLd}, {7'h0, u_uoe_host_model.seenLoad});
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // last address of the sweep is unmapped and must read zero
    for (int i = 0; i < 5; i++) rd(CT + 8'(4 * i), 8'h00, 8'hff);
    xfer(1'b1, uoe_pkg::MASK_ADDR, 8'h07);
    tx(1'b0, 1'b0, ACK, 1'b1);
    chk("dataToggle", 8'h01, {7'h0, dataToggle});
    rd(CT, 8'h03, 8'hff);
    chk("irq", 8'h01, {7'h0, irq});
    rd(uoe_pkg::STAT_ADDR, 8'h01, 8'hff);
    rd(uoe_pkg::STAT_ADDR, 8'h00, 8'hff);
    chk("irq", 8'h00, {7'h0, irq});
    tx(1'b1, 1'b0, NAK, 1'b0);
    // partial reads are finished by releasing, never by flushing
    repeat (2) begin
      fifoByteRead <= 1'b1;
      @(posedge ref_clk);
    end
    fifoByteRead <= 1'b0;
    @(posedge ref_clk);
    chk("fifoRdPtr", 8'h02, fifoRdPtr);
    xfer(1'b1, CT, 8'h00);
    tx(1'b1, 1'b0, ACK, 1'b1);
    xfer(1'b1, CT, 8'h10);
    repeat (4) @(posedge ref_clk);
    rd(CT, 8'h00, 8'hff);
    chk("fifoRdPtr", 8'h00, fifoRdPtr);
    tx(1'b0, 1'b0, ACK, 1'b1);
    xfer(1'b1, CT, 8'h81);
    @(posedge ref_clk);
    chk("dataToggle", 8'h00, {7'h0, dataToggle});
    rd(CT, 8'h03, 8'hff);
    xfer(1'b1, uoe_pkg::CFG_ADDR, 8'h02);
    tx(1'b0, 1'b0, ACK, 1'b1);
    rd(CT, 8'h03, 8'hff);
    xfer(1'b1, CT, 8'h10);
    repeat (4) @(posedge ref_clk);
    rd(CT, 8'h01, 8'hff);
    xfer(1'b1, CT, 8'h00);
    xfer(1'b1, CT, 8'h20);
    tx(1'b1, 1'b0, STL, 1'b0);
    rd(CT, 8'h60, 8'hff);
    rd(uoe_pkg::STAT_ADDR, 8'h02, 8'h02);
    xfer(1'b1, CT, 8'h00);
    rd(CT, 8'h00, 8'hff);
    tx(1'b1, 1'b0, ACK, 1'b1);
    xfer(1'b1, CT, 8'h00);
    tx(1'b1, 1'b1, 3'h0, 1'b0);
    tx(1'b1, 1'b0, ACK, 1'b0);
    xfer(1'b1, uoe_pkg::CFG_ADDR, 8'h01);
    tx(1'b0, 1'b1, 3'h0, 1'b1);
    rd(CT, 8'h0b, 8'hff);
    xfer(1'b1, CT, 8'h01);
    rd(CT, 8'h0b, 8'hff);
    tx(1'b0, 1'b0, 3'h0, 1'b0);
    rd(CT, 8'h0f, 8'hff);
    give_verdict();
  end
endmodule

bind uoe_out_endpoint uoe_out_endpoint_monitor #(.PTR_W(PTR_W)) u_uoe_out_endpoint_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .outTxn(outTxn), .handshake(handshake), .pktLoad(pktLoad), .dataToggle(dataToggle)
);

// ---- uoe_ahb_slave.sv ----
// ahb-lite slave front end with one wait state on reads
`timescale 1ns/1ns
module uoe_ahb_slave (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  input  wire logic [31:0]          rdData,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output uoe_pkg::uoe_regbus_t      bus
);
  typedef struct packed {
    logic                       phaseWr;
    logic                       phaseRd;
    logic                       mapped;
    logic [uoe_pkg::ADDR_W-1:0] addr;
    logic                       hreadyout;
    logic                       hresp;
    logic [31:0]                hrdata;
  } uoe_slave_state_t;

  uoe_slave_state_t s;
  uoe_slave_state_t next_s;

  // the wait state lets a read see a write that finished just before it
  always_comb begin
    next_s = s;
    next_s.phaseWr = 1'b0;
    next_s.phaseRd = 1'b0;
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
    if (s.phaseRd) begin
      next_s.hrdata = s.mapped ? rdData : '0;
    end
    if (hsel && htrans[1] && hready && hsize == uoe_pkg::HSIZE_WORD) begin
      next_s.addr = haddr[uoe_pkg::ADDR_W-1:0];
      next_s.mapped = (haddr[31:uoe_pkg::ADDR_W] == '0);
      next_s.phaseWr = hwrite;
      next_s.phaseRd = !hwrite;
      next_s.hreadyout = hwrite;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign bus.wrEn = s.phaseWr && s.mapped;
  assign bus.rdEn = s.phaseRd && s.mapped;
  assign bus.addr = s.addr;
  assign bus.wdata = hwdata;
endmodule

// ---- uoe_host_model.sv ----
// usb host side: issues out transactions and records the answer
`timescale 1ns/1ns
module uoe_host_model (
  input  wire logic                    ref_clk,
  input  wire uoe_pkg::uoe_handshake_t handshake,
  input  wire logic                    pktLoad,
  output uoe_pkg::uoe_outtxn_t         outTxn
);
  uoe_pkg::uoe_handshake_t seenHs;
  logic                    seenLoad;
  initial outTxn = '0;
  task automatic send(input logic pid, input logic crc);
    outTxn <= '{valid: 1'b1, dataPid: pid, crcErr: crc};
    @(posedge ref_clk);
    // idle qualifiers show the inverse so a stale value is never mistaken for data
    outTxn <= '{valid: 1'b0, dataPid: ~pid, crcErr: ~crc};
    @(posedge ref_clk);
    seenHs = handshake;
    seenLoad = pktLoad;
  endtask
endmodule

// ---- uoe_out_endpoint.sv ----
// out endpoint control and status with ahb-lite register access
// Notes on behaviour
// - control byte at 0x14, resets to zero
// - writing toggle-clear forces data toggle to zero
// - toggle-clear bit always reads back zero
// - stall-sent set on stall, held until cleared
// - flush bit discards the next waiting packet
// - flush resets read pointer unless the fifo is empty, clears packet ready when only one packet is held
// - one flush removes at most one packet, none when the fifo is empty
// - flush bit clears itself when done
// - stall-request answers every out with stall
// - bulk packet sets ready and raises interrupt
// - iso crc error still loads, sets data-error
// - fifo-full reflects one or two packets
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
module uoe_out_endpoint #(
  parameter int PTR_W = 10
) (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire uoe_pkg::uoe_outtxn_t   outTxn,
  input  wire logic                   fifoByteRead,
  output uoe_pkg::uoe_handshake_t     handshake,
  output logic                        pktLoad,
  output logic                        dataToggle,
  output logic [PTR_W-1:0]            fifoRdPtr,
  output logic                        irq
);
  if (PTR_W < 1 || PTR_W > 16) begin : g_chk
    $error("uoe_out_endpoint: PTR_W must lie in 1..16");
  end

  // control-byte writes decoded once, so the endpoint logic only sees commands
  typedef struct packed {
    logic stallWr;
    logic stallVal;
    logic sentClr;
    logic overrunClr;
    logic pktFree;
    logic flush;
    logic toggleClr;
    logic cfgWr;
    logic maskWr;
  } uoe_sw_cmd_t;

  typedef struct packed {
    logic                        stallReq;
    logic                        stallSent;
    logic                        dataErr;
    logic                        overrun;
    logic                        isoMode;
    logic                        dblBuf;
    logic [uoe_pkg::NUM_EVT-1:0] status;
    logic [uoe_pkg::NUM_EVT-1:0] mask;
    logic                        toggle;
    uoe_pkg::uoe_handshake_t     hs;
    logic                        pktLoad;
    logic                        irq;
  } uoe_ep_state_t;

  uoe_ep_state_t s;
  uoe_ep_state_t next_s;

  uoe_pkg::uoe_regbus_t        bus;
  logic [31:0]                 rdData;
  logic [1:0]                  pktCount;
  logic                        flushBusy;
  logic                        readyRise;
  logic                        push;
  logic                        pop;
  logic                        flushReq;
  logic                        pktReady;
  logic                        fifoFull;
  logic                        statRead;
  logic [uoe_pkg::NUM_EVT-1:0] stKeep;
  uoe_sw_cmd_t                 swCmd;
  logic                        wrCtrl;
  logic [7:0]                  wd;

  uoe_ahb_slave u_slave (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .rdData    (rdData),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .bus       (bus)
  );

  uoe_packet_tracker #(
    .PTR_W (PTR_W)
  ) u_track (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .push      (push),
    .pop       (pop),
    .flushReq  (flushReq),
    .byteRead  (fifoByteRead),
    .count     (pktCount),
    .readPtr   (fifoRdPtr),
    .flushBusy (flushBusy),
    .readyRise (readyRise)
  );

  assign pktReady = (pktCount != '0);
  assign fifoFull = (pktCount == (s.dblBuf ? uoe_pkg::PKT_DOUBLE : uoe_pkg::PKT_SINGLE));
  assign statRead = bus.rdEn && (bus.addr == uoe_pkg::STAT_ADDR);

  // a read of the status register clears only the bits it returned
  for (genvar i = 0; i < uoe_pkg::NUM_EVT; i++) begin : g_evt
    assign stKeep[i] = s.status[i] && !statRead;
  end

  // register read mux
  always_comb begin
    logic [7:0] ctrlRd;
    logic [7:0] cfgRd;
    ctrlRd = '0;
    cfgRd = '0;
    ctrlRd[uoe_pkg::BIT_TOGGLE_CLEAR] = 1'b0;
    ctrlRd[uoe_pkg::BIT_STALL_SENT] = s.stallSent;
    ctrlRd[uoe_pkg::BIT_STALL_REQ] = s.stallReq;
    ctrlRd[uoe_pkg::BIT_FLUSH] = flushBusy;
    ctrlRd[uoe_pkg::BIT_DATA_ERR] = s.dataErr;
    ctrlRd[uoe_pkg::BIT_OVERRUN] = s.overrun;
    ctrlRd[uoe_pkg::BIT_FIFO_FULL] = fifoFull;
    ctrlRd[uoe_pkg::BIT_PKT_READY] = pktReady;
    cfgRd[uoe_pkg::CFG_ISO] = s.isoMode;
    cfgRd[uoe_pkg::CFG_DBL] = s.dblBuf;
    case (bus.addr)
      uoe_pkg::CTRL_ADDR: rdData = 32'(ctrlRd);
      uoe_pkg::CFG_ADDR:  rdData = 32'(cfgRd);
      uoe_pkg::STAT_ADDR: rdData = 32'(s.status);
      uoe_pkg::MASK_ADDR: rdData = 32'(s.mask);
      default:            rdData = '0;
    endcase
  end

  // software command decode; data-error and fifo-full positions are never stored
  always_comb begin
    wrCtrl = bus.wrEn && (bus.addr == uoe_pkg::CTRL_ADDR);
    wd = bus.wdata[7:0];
    swCmd = '0;
    if (wrCtrl) begin
      swCmd.stallWr = 1'b1;
      swCmd.stallVal = wd[uoe_pkg::BIT_STALL_REQ];
      swCmd.sentClr = !wd[uoe_pkg::BIT_STALL_SENT];
      swCmd.overrunClr = !wd[uoe_pkg::BIT_OVERRUN];
      // a flush write carries a zero ready bit too; releasing as well would drop two packets
      swCmd.pktFree = !wd[uoe_pkg::BIT_PKT_READY] && !wd[uoe_pkg::BIT_FLUSH];
      // partly read packets are not guarded against here
      swCmd.flush = wd[uoe_pkg::BIT_FLUSH];
      swCmd.toggleClr = wd[uoe_pkg::BIT_TOGGLE_CLEAR];
    end
    swCmd.cfgWr = bus.wrEn && (bus.addr == uoe_pkg::CFG_ADDR);
    swCmd.maskWr = bus.wrEn && (bus.addr == uoe_pkg::MASK_ADDR);
  end

  always_comb begin
    logic [uoe_pkg::NUM_EVT-1:0] evt;
    evt = '0;
    next_s = s;
    next_s.hs.valid = 1'b0;
    next_s.hs.code = uoe_pkg::HS_NONE;
    next_s.pktLoad = 1'b0;
    // release and flush are both ignored while a flush is still running
    pop = swCmd.pktFree && pktReady && !flushBusy;
    flushReq = swCmd.flush && !flushBusy;
    push = 1'b0;

    if (swCmd.stallWr) begin
      next_s.stallReq = swCmd.stallVal;
    end
    if (swCmd.sentClr) begin
      next_s.stallSent = 1'b0;
    end
    if (swCmd.overrunClr) begin
      next_s.overrun = 1'b0;
    end
    if (pop || flushReq) begin
      next_s.dataErr = 1'b0;
    end
    if (swCmd.cfgWr) begin
      next_s.isoMode = bus.wdata[uoe_pkg::CFG_ISO];
      next_s.dblBuf = bus.wdata[uoe_pkg::CFG_DBL];
    end
    if (swCmd.maskWr) begin
      next_s.mask = bus.wdata[uoe_pkg::NUM_EVT-1:0];
    end

    // link side runs after software (toggle-clear excepted, applied last) so a set beats a same-cycle clear
    if (outTxn.valid) begin
      if (s.stallReq) begin
        next_s.hs.valid = 1'b1;
        next_s.hs.code = uoe_pkg::HS_STALL;
        next_s.stallSent = 1'b1;
        evt[uoe_pkg::EVT_STALL] = 1'b1;
      end else if (s.isoMode) begin
        // iso sends no handshake; a full fifo loses the packet
        if (fifoFull) begin
          next_s.overrun = 1'b1;
          evt[uoe_pkg::EVT_OVERRUN_FLAG] = 1'b1;
        end else begin
          push = 1'b1;
          next_s.pktLoad = 1'b1;
          if (outTxn.crcErr) begin
            next_s.dataErr = 1'b1;
          end
        end
      end else if (!outTxn.crcErr) begin
        next_s.hs.valid = 1'b1;
        if (fifoFull) begin
          next_s.hs.code = uoe_pkg::HS_NAK;
        end else begin
          next_s.hs.code = uoe_pkg::HS_ACK;
          // a repeated toggle is acked but not stored again
          if (outTxn.dataPid == s.toggle) begin
            push = 1'b1;
            next_s.pktLoad = 1'b1;
            next_s.toggle = !s.toggle;
          end
        end
      end
    end

    if (swCmd.toggleClr) begin
      next_s.toggle = 1'b0;
    end

    evt[uoe_pkg::EVT_READY] = readyRise;
    next_s.status = stKeep | evt;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign handshake = s.hs;
  assign pktLoad = s.pktLoad;
  assign dataToggle = s.toggle;
  assign irq = s.irq;
endmodule

// ---- uoe_out_endpoint_monitor.sv ----
// bus and link assertions for the out endpoint control block
`timescale 1ns/1ns
module uoe_out_endpoint_monitor #(
  parameter int PTR_W = 10
) (
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire uoe_pkg::uoe_outtxn_t    outTxn,
  input wire uoe_pkg::uoe_handshake_t handshake,
  input wire logic                    pktLoad,
  input wire logic                    dataToggle
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic rdTaken;
  assign rdTaken = hsel && htrans[1] && hready && hsize == uoe_pkg::HSIZE_WORD && !hwrite;

  property p_read_wait; rdTaken |=> !hreadyout ##1 hreadyout; endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rdata_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_hs_cause; handshake.valid |-> $past(outTxn.valid); endproperty
  a_hs_cause: assert property (p_hs_cause)
    else $error("handshake without transaction");
  property p_load_cause; pktLoad |-> $past(outTxn.valid); endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("load without transaction");
  property p_load_ack; pktLoad && handshake.valid |-> handshake.code == uoe_pkg::HS_ACK; endproperty
  a_load_ack: assert property (p_load_ack)
    else $error("loaded packet not acked");
  property p_stall_noload;
    handshake.valid && handshake.code == uoe_pkg::HS_STALL |-> !pktLoad;
  endproperty
  a_stall_noload: assert property (p_stall_noload)
    else $error("stalled packet loaded");
  property p_nak_noload;
    handshake.valid && handshake.code == uoe_pkg::HS_NAK |-> !pktLoad;
  endproperty
  a_nak_noload: assert property (p_nak_noload)
    else $error("refused packet loaded");
  property p_toggle_flip; pktLoad && handshake.valid |-> dataToggle != $past(dataToggle); endproperty
  a_toggle_flip: assert property (p_toggle_flip)
    else $error("toggle did not flip on load");
  property p_crc_silent; outTxn.valid && outTxn.crcErr |=> !handshake.valid; endproperty
  a_crc_silent: assert property (p_crc_silent)
    else $error("handshake on damaged packet");
endmodule

// ---- uoe_packet_tracker.sv ----
// counts buffered out packets, keeps the read pointer, runs the flush
`timescale 1ns/1ns
module uoe_packet_tracker #(
  parameter int PTR_W = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic             flushReq,
  input  wire logic             byteRead,
  output logic [1:0]            count,
  output logic [PTR_W-1:0]      readPtr,
  output logic                  flushBusy,
  output logic                  readyRise
);
  if (PTR_W < 1 || PTR_W > 16) begin : g_chk
    $error("uoe_packet_tracker: PTR_W must lie in 1..16");
  end

  typedef struct packed {
    logic [1:0]          count;
    logic [PTR_W-1:0]    readPtr;
    uoe_pkg::uoe_flush_t fl;
    logic                readyRise;
  } uoe_track_state_t;

  uoe_track_state_t s;
  uoe_track_state_t next_s;

  always_comb begin
    logic drop;
    logic rel;
    drop = 1'b0;
    rel = 1'b0;
    next_s = s;
    next_s.readyRise = 1'b0;
    case (s.fl)
      uoe_pkg::FL_IDLE: begin
        if (flushReq) next_s.fl = uoe_pkg::FL_DROP;
      end
      uoe_pkg::FL_DROP: begin
        drop = 1'b1;
        next_s.fl = uoe_pkg::FL_DONE;
      end
      uoe_pkg::FL_DONE: next_s.fl = uoe_pkg::FL_IDLE;
      default: next_s.fl = uoe_pkg::FL_IDLE;
    endcase
    // drop and pop together still release only one packet
    rel = (pop || drop) && (s.count != '0);
    if (byteRead) next_s.readPtr = s.readPtr + 1'b1;
    if (rel) next_s.readPtr = '0;
    next_s.count = s.count + {1'b0, push} - {1'b0, rel};
    if (next_s.count != '0 && (s.count == '0 || rel)) next_s.readyRise = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign readPtr = s.readPtr;
  assign flushBusy = (s.fl != uoe_pkg::FL_IDLE);
  assign readyRise = s.readyRise;
endmodule

// ---- uoe_pkg.sv ----
// shared constants and types for the usb out endpoint control block
package uoe_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h14;
  localparam logic [7:0] CFG_ADDR  = 8'h18;
  localparam logic [7:0] STAT_ADDR = 8'h1c;
  localparam logic [7:0] MASK_ADDR = 8'h20;
  localparam int unsigned ADDR_W   = 8;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // out_endpoint_control_low bit positions
  localparam int BIT_TOGGLE_CLEAR = 7;
  localparam int BIT_STALL_SENT   = 6;
  localparam int BIT_STALL_REQ    = 5;
  localparam int BIT_FLUSH        = 4;
  localparam int BIT_DATA_ERR     = 3;
  localparam int BIT_OVERRUN      = 2;
  localparam int BIT_FIFO_FULL    = 1;
  localparam int BIT_PKT_READY    = 0;

  // configuration bits
  localparam int CFG_ISO = 0;
  localparam int CFG_DBL = 1;

  // interrupt status and mask layout
  localparam int EVT_READY = 0;
  localparam int EVT_STALL = 1;
  localparam int EVT_OVERRUN_FLAG = 2;
  localparam int NUM_EVT   = 3;

  // handshake codes toward the serial engine
  localparam logic [1:0] HS_NONE  = 2'h0;
  localparam logic [1:0] HS_ACK   = 2'h1;
  localparam logic [1:0] HS_NAK   = 2'h2;
  localparam logic [1:0] HS_STALL = 2'h3;

  // packets held when the fifo counts as full
  localparam logic [1:0] PKT_SINGLE = 2'h1;
  localparam logic [1:0] PKT_DOUBLE = 2'h2;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } uoe_regbus_t;

  typedef struct packed {
    logic valid;
    logic dataPid;
    logic crcErr;
  } uoe_outtxn_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } uoe_handshake_t;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_DROP = 2'b01,
    FL_DONE = 2'b11
  } uoe_flush_t;
endpackage
